// >>> rtl/rx_stat_regs.svh
// Register indices, field positions, reset values for the receive statistics counters
`ifndef RX_STAT_REGS_SVH
`define RX_STAT_REGS_SVH

// ****************************************************************
// Register indices (byte address = 4 * index)
// ****************************************************************
`define RX_CTRL_IDX          16'hF010
`define RX_PKT_CNT_LO_IDX    16'hF021
`define RX_PKT_CNT_MID_IDX   16'hF022
`define RX_PKT_CNT_HI_IDX    16'hF023
`define RX_BYTE_CNT_LO_IDX   16'hF024
`define RX_BYTE_CNT_MID_IDX  16'hF025
`define RX_BYTE_CNT_HI_IDX   16'hF026
`define RX_CRC_CNT_LO_IDX    16'hF027
`define RX_CRC_CNT_MID_IDX   16'hF028
`define RX_CRC_CNT_HI_IDX    16'hF029

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define RX_CTRL_COR_BIT      14
`define RX_CTRL_CLR_BIT      6
`define RX_CTRL_WR_MASK      16'h4040
`define RX_CTRL_RESET        16'h0000
`define RX_COUNT_RESET       48'h0000_0000_0000
`define RX_WORD_RESET        16'h0000

`endif

// >>> rtl/rx_stat_pkg.sv
// Types shared by the receive statistics counter block
package rx_stat_pkg;

   // ****************************************************************
   // Receive events from the packet checker, same clock domain
   // ****************************************************************
   typedef struct packed {
      logic       pkt_done;
      logic       crc_err;
      logic [7:0] byte_inc;
   } rx_event_t;

   // ****************************************************************
   // Counter selection
   // ****************************************************************
   typedef enum logic [1:0] {
      CNT_PKT  = 2'h0,
      CNT_BYTE = 2'h1,
      CNT_CRC  = 2'h2
   } cnt_sel_t;

   // ****************************************************************
   // Word within a 48-bit counter
   // ****************************************************************
   typedef enum logic [1:0] {
      WORD_LO   = 2'h0,
      WORD_MID  = 2'h1,
      WORD_HI   = 2'h2,
      WORD_NONE = 2'h3
   } word_sel_t;

endpackage

// >>> rtl/rx_packet_stat_counters.sv
// Receive packet, byte and CRC-error statistics counters behind a Wishbone slave
//
// Contract
// - 48-bit received packet count, three words
// - 48-bit received byte count, preamble included
// - 48-bit CRC-error packet count, words exposed
// - Clear-on-read off: reads leave counters unchanged
// - Clear-on-read off: clear on reset-bit rising edge
// - Clear-on-read on: reading a word clears it
// - Packet upper words refresh on low read
// - Byte upper words refresh on low read
// - CRC upper words refresh on low read
`include "rx_stat_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_packet_stat_counters (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Wishbone classic slave
   input  wire logic [31:0]           adr_i,
   input  wire logic [31:0]           dat_i,
   output logic      [31:0]           dat_o,
   input  wire logic                  we_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   output logic                       ack_o,
   // Receive events from the checker
   input  wire rx_stat_pkg::rx_event_t ev_i
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Natural 48-bit wrap on overflow
   function automatic logic [47:0] wrap_add(
      input logic [47:0] value,
      input logic [7:0]  inc
   );
      wrap_add = value + {40'h0, inc};
   endfunction

   // Index of the low word of a counter
   function automatic logic [15:0] lo_index(
      input rx_stat_pkg::cnt_sel_t sel
   );
      case (sel)
         rx_stat_pkg::CNT_PKT: begin
            lo_index = `RX_PKT_CNT_LO_IDX;
         end
         rx_stat_pkg::CNT_BYTE: begin
            lo_index = `RX_BYTE_CNT_LO_IDX;
         end
         rx_stat_pkg::CNT_CRC: begin
            lo_index = `RX_CRC_CNT_LO_IDX;
         end
         default: begin
            lo_index = 16'hFFFF;
         end
      endcase
   endfunction

   // Which word of a counter an index hits
   function automatic rx_stat_pkg::word_sel_t word_of(
      input logic [15:0]           idx,
      input rx_stat_pkg::cnt_sel_t sel
   );
      logic [15:0] base;
      base = lo_index(sel);
      if (idx == base) begin
         word_of = rx_stat_pkg::WORD_LO;
      end else if (idx == base + 16'h0001) begin
         word_of = rx_stat_pkg::WORD_MID;
      end else if (idx == base + 16'h0002) begin
         word_of = rx_stat_pkg::WORD_HI;
      end else begin
         word_of = rx_stat_pkg::WORD_NONE;
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic [47:0] live      [3];
   logic [47:0] snap      [3];
   logic [47:0] next_live [3];
   logic [47:0] next_snap [3];
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic        clr_q;
   logic        next_clr_q;
   logic        next_ack;
   logic [31:0] next_dat;
   logic [7:0]  inc       [3];
   logic [15:0] idx;
   logic        req;
   logic        cor;
   logic        clr_edge;

   assign idx      = adr_i[17:2];
   assign req      = cyc_i & stb_i & ~ack_o;
   assign cor      = ctrl[`RX_CTRL_COR_BIT];
   assign clr_edge = ctrl[`RX_CTRL_CLR_BIT] & ~clr_q;

   // Per-counter increments this cycle
   assign inc[0] = {7'h00, ev_i.pkt_done};
   assign inc[1] = ev_i.byte_inc;
   assign inc[2] = {7'h00, ev_i.pkt_done & ev_i.crc_err};

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      rx_stat_pkg::cnt_sel_t   sel;
      rx_stat_pkg::word_sel_t  word;
      sel        = rx_stat_pkg::CNT_PKT;
      word       = rx_stat_pkg::WORD_NONE;
      next_ctrl  = ctrl;
      next_clr_q = ctrl[`RX_CTRL_CLR_BIT];
      next_ack   = 1'b0;
      next_dat   = 32'h0000_0000;
      for (int k = 0; k < 3; k++) begin
         next_live[k] = wrap_add(live[k], inc[k]);
         next_snap[k] = snap[k];
      end

      if (req) begin
         next_ack = 1'b1;
         if (idx == `RX_CTRL_IDX) begin
            if (we_i) begin
               if (sel_i[0]) begin
                  next_ctrl[7:0] = dat_i[7:0] & 8'(`RX_CTRL_WR_MASK);
               end
               if (sel_i[1]) begin
                  next_ctrl[15:8] = dat_i[15:8] & 8'(`RX_CTRL_WR_MASK >> 8);
               end
            end else begin
               next_dat[15:0] = ctrl;
            end
         end
         for (int k = 0; k < 3; k++) begin
            sel  = rx_stat_pkg::cnt_sel_t'(k[1:0]);
            word = word_of(idx, sel);
            // Writes fall through here untouched
            if (!we_i) begin
               case (word)
                  rx_stat_pkg::WORD_LO: begin
                     next_dat[15:0] = live[k][15:0];
                     next_snap[k]   = live[k];
                     if (cor) begin
                        // Events in this cycle start the new count
                        next_live[k] = {40'h0, inc[k]};
                     end
                  end
                  rx_stat_pkg::WORD_MID: begin
                     next_dat[15:0] = snap[k][31:16];
                     if (cor) begin
                        next_snap[k][31:16] = `RX_WORD_RESET;
                     end
                  end
                  rx_stat_pkg::WORD_HI: begin
                     next_dat[15:0] = snap[k][47:32];
                     if (cor) begin
                        next_snap[k][47:32] = `RX_WORD_RESET;
                     end
                  end
                  default: begin
                     next_dat = next_dat;
                  end
               endcase
            end
         end
      end

      // Level on the reset bit must not hold counters at zero
      if (clr_edge && !cor) begin
         for (int k = 0; k < 3; k++) begin
            next_live[k] = {40'h0, inc[k]};
            next_snap[k] = `RX_COUNT_RESET;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl  <= `RX_CTRL_RESET;
         clr_q <= 1'b0;
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         for (int k = 0; k < 3; k++) begin
            live[k] <= `RX_COUNT_RESET;
            snap[k] <= `RX_COUNT_RESET;
         end
      end else begin
         ctrl  <= next_ctrl;
         clr_q <= next_clr_q;
         ack_o <= next_ack;
         dat_o <= next_dat;
         for (int k = 0; k < 3; k++) begin
            live[k] <= next_live[k];
            snap[k] <= next_snap[k];
         end
      end
   end

endmodule

`default_nettype wire

// >>> test/rx_packet_stat_counters_sva.sv
// Bus and counter assertions for the receive statistics block
`include "rx_stat_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rx_packet_stat_counters_sva (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic [31:0]            adr_i,
   input wire logic [31:0]            dat_i,
   input wire logic [31:0]            dat_o,
   input wire logic                   we_i,
   input wire logic [3:0]             sel_i,
   input wire logic                   cyc_i,
   input wire logic                   stb_i,
   input wire logic                   ack_o,
   input wire rx_stat_pkg::rx_event_t ev_i
);
   logic [15:0] idx;
   logic        cor;
   assign idx = adr_i[17:2];
   // Mirror of the clear-on-read bit, to tell the two read modes apart
   always_ff @(posedge clk_i) begin
      if (rst_i) cor <= 1'b0;
      else if (cyc_i && stb_i && we_i && !ack_o && idx == `RX_CTRL_IDX && sel_i[1]) cor <= dat_i[14];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence rd_mid;
      cyc_i && stb_i && !ack_o && !we_i && idx == `RX_PKT_CNT_MID_IDX;
   endsequence
   // Two middle-word reads with nothing in between: snapshot must not move unless clear-on-read is set
   sequence mid_again;
      rd_mid ##1 ack_o ##2 rd_mid;
   endsequence
   AST_ACK_TAKEN: assert property (take |=> ack_o) else $error("no ack after request");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
      else $error("ack without request");
   AST_UPPER_ZERO: assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("upper data set");
   AST_UNMAPPED_ZERO: assert property ((take ##0 (!we_i && !(idx inside {`RX_CTRL_IDX,
      [`RX_PKT_CNT_LO_IDX:`RX_CRC_CNT_HI_IDX]}))) |=> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_CTRL_READ: assert property ((take ##0 (!we_i && idx == `RX_CTRL_IDX)) |=>
      (dat_o[15:0] & 16'hBFBF) == 16'h0000 && dat_o[14] == cor) else $error("control readback");
   AST_MID_HOLD: assert property ((!cor ##0 mid_again) |=> dat_o == $past(dat_o, 3))
      else $error("middle word changed by a read");
   AST_MID_CLEAR: assert property ((cor ##0 mid_again) |=> dat_o == 32'h0000_0000)
      else $error("middle word not cleared by read");
endmodule
bind rx_packet_stat_counters rx_packet_stat_counters_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .ev_i(ev_i));
`default_nettype wire

// >>> test/rx_packet_stat_counters_test.sv
// Self-checking bench for the receive statistics counters
`include "rx_stat_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rx_packet_stat_counters_test;
   logic                   clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
   logic [31:0]            adr_i, dat_i, dat_o, r;
   logic [3:0]             sel_i;
   rx_stat_pkg::rx_event_t ev_i;
   logic [47:0]            m [3];
   int                     mismatches, checks;
   rx_packet_stat_counters DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .ev_i(ev_i));
   always #2.5 clk_i = ~clk_i;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] ix, input logic [15:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'hF};
      adr_i <= {14'h0000, ix, 2'h0};
      dat_i <= {16'h0000, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         mismatches++;
         complete_run;
      end
      rd = dat_o;
      {cyc_i, stb_i} <= 2'h0;
   endtask
   function automatic logic [47:0] bump(logic [47:0] v, rx_stat_pkg::rx_event_t e, int c);
      return v + ((c == 0) ? 48'(e.pkt_done) : (c == 1) ? 48'(e.byte_inc)
                  : 48'(e.pkt_done & e.crc_err));
   endfunction
   task automatic traffic(input int n);
      rx_stat_pkg::rx_event_t e;
      repeat (n) begin
         @(posedge clk_i);
         e = 10'($urandom);
         ev_i <= e;
         for (int c = 0; c < 3; c++) m[c] = bump(m[c], e, c);
      end
      @(posedge clk_i);
      ev_i <= '0;
      repeat (2) @(posedge clk_i);
   endtask
   // Low, middle, middle again back to back, then high
   task automatic rd_cnt(input int c, input logic cor);
      logic [15:0] b;
      logic [31:0] lo, mid, hi, mid2;
      b = 16'hF021 + 16'(3 * c);
      bus(1'b0, b, 16'h0000, lo);
      bus(1'b0, b + 16'h0001, 16'h0000, mid);
      bus(1'b0, b + 16'h0001, 16'h0000, mid2);
      bus(1'b0, b + 16'h0002, 16'h0000, hi);
      chk("count", {hi[15:0], mid[15:0], lo[15:0]}, m[c]);
      chk("middle again", 48'(mid2), cor ? 48'h0 : 48'(m[c][31:16]));
      if (cor) m[c] = '0;
   endtask
   task automatic rd_all(input logic cor);
      for (int c = 0; c < 3; c++) rd_cnt(c, cor);
   endtask
   initial begin
      {clk_i, rst_i, we_i, cyc_i, stb_i, adr_i, dat_i, sel_i, ev_i} = '0;
      rst_i = 1'b1;
      for (int c = 0; c < 3; c++) m[c] = '0;
      void'($urandom(32'h636EA467));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_all(1'b0);
      bus(1'b0, `RX_CTRL_IDX, 16'h0000, r);
      chk("control", 48'(r), 48'h0);
      $display("test reset done");
      traffic(200);
      for (int c = 0; c < 9; c++) bus(1'b1, 16'hF021 + 16'(c), 16'($urandom), r);
      bus(1'b1, 16'hF011, 16'hFFFF, r);
      bus(1'b0, 16'hF011, 16'h0000, r);
      chk("unmapped", 48'(r), 48'h0);
      repeat (2) rd_all(1'b0);
      $display("test counting done");
      bus(1'b1, `RX_CTRL_IDX, 16'h0040, r);
      for (int c = 0; c < 3; c++) m[c] = '0;
      rd_all(1'b0);
      traffic(50);
      bus(1'b1, `RX_CTRL_IDX, 16'h0040, r);
      rd_all(1'b0);
      bus(1'b1, `RX_CTRL_IDX, 16'h0000, r);
      bus(1'b1, `RX_CTRL_IDX, 16'h0040, r);
      for (int c = 0; c < 3; c++) m[c] = '0;
      rd_all(1'b0);
      $display("test edge clear done");
      bus(1'b1, `RX_CTRL_IDX, 16'h4000, r);
      bus(1'b0, `RX_CTRL_IDX, 16'h0000, r);
      chk("control", 48'(r), 48'h4000);
      traffic(100);
      repeat (2) rd_all(1'b1);
      $display("test clear on read done");
      complete_run;
   end
endmodule
`default_nettype wire
